//--- hdl/pio_cfg.svh
/*
   Register map, field layout, reset values and pin options of the
   parallel I/O block. Assumes inclusion by bare name from pio files.
*/
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH

`define PIO_ADDR_W 5
// address is {port[1:0], register[2:0]}
`define PIO_REG_DATA 3'h0
`define PIO_REG_DIR 3'h1
`define PIO_REG_PULL 3'h2
`define PIO_REG_SLEW 3'h3
`define PIO_REG_DRIVE 3'h4
`define PIO_PORTA_LSB 0
`define PIO_PORTB_LSB 4
`define PIO_PORTC_LSB 12
`define PIO_RST_PINS 16'h0000
`define PIO_RST_BYTE 8'h00
// pins whose input buffer does not exist
`define PIO_OUT_ONLY 16'h0000

`endif

//--- hdl/pio_pin_ctl.sv
/*
   Per-pin pad control: priority of analog, shared peripheral and GPIO.
   Assumes all inputs are on the mclk domain; purely combinational.
*/
module pio_pin_ctl (
   input wire logic outOnly,
   input wire logic dirBit,
   input wire logic dataBit,
   input wire logic pullEn,
   input wire logic slewEn,
   input wire logic driveHi,
   input wire logic perEn,
   input wire logic perOe,
   input wire logic perDo,
   input wire logic anaEn,
   output logic padOe,
   output logic padOut,
   output logic padIe,
   output logic padPull,
   output logic padSlew,
   output logic padDrive
);
   logic wantOut;

   always_comb begin
      // peripheral owns the output buffer when enabled
      wantOut = perEn ? perOe : dirBit;
      // analog wins over both digital owners
      padOe = wantOut & ~anaEn;
      padOut = perEn ? perDo : dataBit;
      padIe = ~anaEn & ~outOnly;
      padPull = pullEn & ~wantOut & ~anaEn;
      padSlew = slewEn & padOe;
      padDrive = driveHi;
   end
endmodule : pio_pin_ctl

//--- hdl/pio_pkg.sv
/*
   Types shared by the parallel I/O block files.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package pio_pkg;
   typedef logic [15:0] pio_pins_t;
   typedef logic [7:0] pio_byte_t;
   typedef enum {PIO_PORT_A, PIO_PORT_B, PIO_PORT_C, PIO_PORT_NONE} pio_port_e;
endpackage : pio_pkg

//--- hdl/pio_port.sv
/*
   Parallel I/O block: three ports, sixteen pins, with data, direction,
   pull-up, slew and drive registers on a plain strobe port.
   Assumes peripheral and analog enables come from mclk-domain logic and
   pad input levels are asynchronous.
*/
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`include "pio_cfg.svh"

module pio_port (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [`PIO_ADDR_W-1:0] regAddr,
   input pio_pkg::pio_byte_t regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output pio_pkg::pio_byte_t regRdata,
   input pio_pkg::pio_pins_t padIn,
   input pio_pkg::pio_pins_t perEn,
   input pio_pkg::pio_pins_t perOe,
   input pio_pkg::pio_pins_t perDo,
   input pio_pkg::pio_pins_t anaEn,
   output pio_pkg::pio_pins_t padOut,
   output pio_pkg::pio_pins_t padOe,
   output pio_pkg::pio_pins_t padIe,
   output pio_pkg::pio_pins_t padPullup,
   output pio_pkg::pio_pins_t padSlew,
   output pio_pkg::pio_pins_t padHighDrive,
   output pio_pkg::pio_pins_t perDi
);
   import pio_pkg::*;

   pio_pins_t dataQ;
   pio_pins_t dirQ;
   pio_pins_t pullQ;
   pio_pins_t slewQ;
   pio_pins_t drvQ;
   pio_pins_t syncIn;
   pio_pins_t oeD;
   pio_pins_t outD;
   pio_pins_t ieD;
   pio_pins_t pullD;
   pio_pins_t slewD;
   pio_pins_t drvD;
   pio_pins_t inGated;
   pio_pins_t readView;
   pio_port_e port;
   logic [2:0] sel;
   logic hit;
   pio_byte_t rdD;

   function automatic pio_port_e portOf(input logic [`PIO_ADDR_W-1:0] a);
      case (a[4:3])
         2'h0: portOf = PIO_PORT_A;
         2'h1: portOf = PIO_PORT_B;
         2'h2: portOf = PIO_PORT_C;
         default: portOf = PIO_PORT_NONE;
      endcase
   endfunction : portOf

   // port A holds pins 3:0, port B 11:4, port C 15:12
   function automatic pio_byte_t portGet(input pio_pins_t v, input pio_port_e p);
      case (p)
         PIO_PORT_A: portGet = {4'h0, v[`PIO_PORTB_LSB-1:`PIO_PORTA_LSB]};
         PIO_PORT_B: portGet = v[`PIO_PORTC_LSB-1:`PIO_PORTB_LSB];
         PIO_PORT_C: portGet = {4'h0, v[15:`PIO_PORTC_LSB]};
         default: portGet = `PIO_RST_BYTE;
      endcase
   endfunction : portGet

   function automatic pio_pins_t portPut(input pio_pins_t v, input pio_port_e p,
                                         input pio_byte_t b);
      portPut = v;
      case (p)
         PIO_PORT_A: portPut[`PIO_PORTB_LSB-1:`PIO_PORTA_LSB] = b[3:0];
         PIO_PORT_B: portPut[`PIO_PORTC_LSB-1:`PIO_PORTB_LSB] = b;
         PIO_PORT_C: portPut[15:`PIO_PORTC_LSB] = b[3:0];
         default: portPut = v;
      endcase
   endfunction : portPut

   function automatic logic wrHit(input logic we, input logic [`PIO_ADDR_W-1:0] a,
                                  input logic [2:0] r);
      wrHit = we && (portOf(a) != PIO_PORT_NONE) && (a[2:0] == r);
   endfunction : wrHit

   assign port = portOf(regAddr);
   assign sel = regAddr[2:0];
   assign hit = (port != PIO_PORT_NONE) && (sel <= `PIO_REG_DRIVE);

   // data latch keeps its value even while a peripheral owns the pin
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         dataQ <= `PIO_RST_PINS;
      end else if (wrHit(regWr, regAddr, `PIO_REG_DATA)) begin
         dataQ <= portPut(dataQ, port, regWdata);
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         dirQ <= `PIO_RST_PINS;
      end else if (wrHit(regWr, regAddr, `PIO_REG_DIR)) begin
         dirQ <= portPut(dirQ, port, regWdata);
      end
   end

   // pin control group has its own writes only
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pullQ <= `PIO_RST_PINS;
      end else if (wrHit(regWr, regAddr, `PIO_REG_PULL)) begin
         pullQ <= portPut(pullQ, port, regWdata);
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         slewQ <= `PIO_RST_PINS;
      end else if (wrHit(regWr, regAddr, `PIO_REG_SLEW)) begin
         slewQ <= portPut(slewQ, port, regWdata);
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         drvQ <= `PIO_RST_PINS;
      end else if (wrHit(regWr, regAddr, `PIO_REG_DRIVE)) begin
         drvQ <= portPut(drvQ, port, regWdata);
      end
   end

   pio_sync u_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .async(padIn),
      .synced(syncIn)
   );

   localparam pio_pins_t OUT_ONLY = `PIO_OUT_ONLY;

   for (genvar i = 0; i < 16; i++) begin : g_pin
      pio_pin_ctl u_ctl (
         .outOnly(OUT_ONLY[i]),
         .dirBit(dirQ[i]),
         .dataBit(dataQ[i]),
         .pullEn(pullQ[i]),
         .slewEn(slewQ[i]),
         .driveHi(drvQ[i]),
         .perEn(perEn[i]),
         .perOe(perOe[i]),
         .perDo(perDo[i]),
         .anaEn(anaEn[i]),
         .padOe(oeD[i]),
         .padOut(outD[i]),
         .padIe(ieD[i]),
         .padPull(pullD[i]),
         .padSlew(slewD[i]),
         .padDrive(drvD[i])
      );
   end

   // disabled input buffer reads as zero
   assign inGated = syncIn & ieD;
   // direction picks the read source even under a peripheral
   assign readView = (dirQ & dataQ) | (~dirQ & inGated);

   always_comb begin
      rdD = `PIO_RST_BYTE;
      if (regRd && hit) begin
         case (sel)
            `PIO_REG_DATA: rdD = portGet(readView, port);
            `PIO_REG_DIR: rdD = portGet(dirQ, port);
            `PIO_REG_PULL: rdD = portGet(pullQ, port);
            `PIO_REG_SLEW: rdD = portGet(slewQ, port);
            `PIO_REG_DRIVE: rdD = portGet(drvQ, port);
            default: rdD = `PIO_RST_BYTE;
         endcase
      end
   end

   // read data stands for the one cycle after the strobe only
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdata <= `PIO_RST_BYTE;
      end else begin
         regRdata <= rdD;
      end
   end

   // pad controls registered: one cycle after any cause
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         padOe <= `PIO_RST_PINS;
         padOut <= `PIO_RST_PINS;
         padIe <= `PIO_RST_PINS;
         padPullup <= `PIO_RST_PINS;
      end else begin
         padOe <= oeD;
         padOut <= outD;
         padIe <= ieD;
         padPullup <= pullD;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         padSlew <= `PIO_RST_PINS;
         padHighDrive <= `PIO_RST_PINS;
      end else begin
         padSlew <= slewD;
         padHighDrive <= drvD;
      end
   end

   // peripherals see the same gated level that port reads see on pins with dirQ clear; set pins read the data latch
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         perDi <= `PIO_RST_PINS;
      end else begin
         perDi <= inGated;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   property p_reset_clean;
      $fell(sys_rst) |-> (dirQ == '0) && (pullQ == '0) && (slewQ == '0) && (drvQ == '0);
   endproperty
   a_reset_clean: assert property (p_reset_clean)
      else $error("control bits not cleared by reset");

   property p_oe_follows;
      padOe == $past(((dirQ & ~perEn) | (perOe & perEn)) & ~anaEn);
   endproperty
   a_oe_follows: assert property (p_oe_follows)
      else $error("output enable does not follow owner");

   property p_per_data;
      ((padOut ^ $past(perDo)) & $past(perEn)) == '0;
   endproperty
   a_per_data: assert property (p_per_data)
      else $error("peripheral data not on pad");

   property p_analog_off;
      ((padOe | padIe | padPullup) & $past(anaEn)) == '0;
   endproperty
   a_analog_off: assert property (p_analog_off)
      else $error("buffer active under analog function");

   // first edge after release still shows the reset value of the buffer enable
   property p_input_on;
      !$past(sys_rst) |-> padIe == $past(~anaEn & ~OUT_ONLY);
   endproperty
   a_input_on: assert property (p_input_on)
      else $error("input buffer state wrong");

   property p_pull_off;
      (padPullup & ($past(perEn & perOe) | $past(dirQ & ~perEn))) == '0;
   endproperty
   a_pull_off: assert property (p_pull_off)
      else $error("pull-up on while pin drives");

   property p_pull_on;
      padPullup == $past(pullQ & ~anaEn & ~((dirQ & ~perEn) | (perOe & perEn)));
   endproperty
   a_pull_on: assert property (p_pull_on)
      else $error("pull-up enable not honoured");

   property p_slew_in;
      (padSlew & ~padOe) == '0;
   endproperty
   a_slew_in: assert property (p_slew_in)
      else $error("slew active on input");

   property p_drive;
      padHighDrive == $past(drvQ);
   endproperty
   a_drive: assert property (p_drive)
      else $error("drive select not passed");

   property p_indep;
      regWr && (sel >= `PIO_REG_PULL) |=> $stable(dataQ) && $stable(dirQ);
   endproperty
   a_indep: assert property (p_indep)
      else $error("pin control write changed data or direction");

   property p_read_zero;
      regRd && (port == PIO_PORT_A) && (sel == `PIO_REG_DATA) &&
         (dirQ[3:0] == 4'h0) && (ieD[3:0] == 4'h0) |=> regRdata == 8'h00;
   endproperty
   a_read_zero: assert property (p_read_zero)
      else $error("disabled input did not read zero");

   property p_read_latch;
      regRd && (port == PIO_PORT_B) && (sel == `PIO_REG_DATA) &&
         (dirQ[11:4] == 8'hFF) |=> regRdata == $past(dataQ[11:4]);
   endproperty
   a_read_latch: assert property (p_read_latch)
      else $error("output pin read did not return latch");

   property p_read_pin;
      regRd && (port == PIO_PORT_C) && (sel == `PIO_REG_DATA) &&
         (dirQ[15:12] == 4'h0) |=> regRdata == {4'h0, $past(syncIn[15:12] & ieD[15:12])};
   endproperty
   a_read_pin: assert property (p_read_pin)
      else $error("input pin read did not return pin level");

   property p_read_only_once;
      !regRd |=> regRdata == 8'h00;
   endproperty
   a_read_only_once: assert property (p_read_only_once)
      else $error("read data stood beyond one cycle");
endmodule : pio_port

//--- hdl/pio_sync.sv
/*
   Two-stage synchroniser for the pad input levels.
   Assumes pad levels are asynchronous to mclk.
*/
module pio_sync (
   input wire logic mclk,
   input wire logic sys_rst,
   input pio_pkg::pio_pins_t async,
   output pio_pkg::pio_pins_t synced
);
   import pio_pkg::*;

   pio_pins_t meta_q;

   // first stage feeds only the second
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= '0;
         synced <= '0;
      end else begin
         meta_q <= async;
         synced <= meta_q;
      end
   end
endmodule : pio_sync

//--- verification/pio_pad_model.sv
/*
   Board-side model of the sixteen pads: external drivers, pull-ups.
   Assumes pad outputs come from mclk-domain registers.
*/
module pio_pad_model (
   input wire logic mclk,
   input pio_pkg::pio_pins_t padOut,
   input pio_pkg::pio_pins_t padOe,
   input pio_pkg::pio_pins_t padPullup,
   input pio_pkg::pio_pins_t extLvl,
   input pio_pkg::pio_pins_t extEn,
   output pio_pkg::pio_pins_t padIn
);
   timeunit 1ns;
   timeprecision 1ps;
   import pio_pkg::*;
   // undriven, unpulled pads wander: never trust a floating level
   pio_pins_t floatQ = 16'h0000;
   always @(posedge mclk) floatQ <= ~floatQ;
   assign padIn = (padOe & padOut) | (~padOe & extEn & extLvl)
      | (~padOe & ~extEn & padPullup) | (~padOe & ~extEn & ~padPullup & floatQ);
endmodule : pio_pad_model

//--- verification/testbench.sv
/*
   Random-configuration bench for the parallel I/O block with a bit model.
   Assumes pio_port, pio_pad_model and pio_pkg are compiled first.
*/
`include "pio_cfg.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pio_pkg::*;
   logic mclk = 1'b0;
   logic sysRst = 1'b1;
   logic [`PIO_ADDR_W-1:0] regAddr = 5'h00;
   pio_byte_t regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   pio_byte_t regRdata;
   pio_pins_t perEn = 16'h0000, perOe = 16'h0000, perDo = 16'h0000, anaEn = 16'h0000;
   pio_pins_t extLvl = 16'h0000, extEn = 16'hFFFF, padIn;
   pio_pins_t padOut, padOe, padIe, padPullup, padSlew, padHighDrive, perDi;
   pio_pins_t mdl [5];
   pio_pins_t xOe, xPu, xPin, xOut;
   int portLsb [3] = '{0, 4, 12};
   int portW [3] = '{4, 8, 4};
   int fail_count = 0;
   int check_count = 0;

   always #2 mclk = ~mclk;

   pio_port dut (.mclk(mclk), .sys_rst(sysRst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .padIn(padIn), .perEn(perEn),
      .perOe(perOe), .perDo(perDo), .anaEn(anaEn), .padOut(padOut), .padOe(padOe),
      .padIe(padIe), .padPullup(padPullup), .padSlew(padSlew),
      .padHighDrive(padHighDrive), .perDi(perDi));
   pio_pad_model pads (.mclk(mclk), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
      .extLvl(extLvl), .extEn(extEn), .padIn(padIn));

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic wr(input int p, input int r, input logic [7:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= {p[1:0], r[2:0]};
      regWdata <= d;
      @(posedge mclk);
      regWr <= 1'b0;
      // unmapped port or register: nothing may change
      if (p < 3 && r < 5) begin
         for (int i = 0; i < portW[p]; i++) mdl[r][portLsb[p] + i] = d[i];
      end
   endtask : wr

   task automatic rd(input int p, input int r);
      logic [7:0] exp;
      exp = 8'h00;
      if (p < 3 && r < 5) begin
         for (int i = 0; i < portW[p]; i++) begin
            int b;
            b = portLsb[p] + i;
            exp[i] = (r != 0) ? mdl[r][b] : (mdl[1][b] ? mdl[0][b] : xPin[b] & ~anaEn[b]);
         end
      end
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= {p[1:0], r[2:0]};
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      chk("regRdata", {8'h00, regRdata}, {8'h00, exp});
   endtask : rd

   task automatic check_all();
      extEn <= ~mdl[2];
      repeat (6) @(posedge mclk);
      #1;
      xOe = ~anaEn & ((perEn & perOe) | (~perEn & mdl[1]));
      xPu = mdl[2] & ~anaEn & ~((perEn & perOe) | (~perEn & mdl[1]));
      xOut = (perEn & perDo) | (~perEn & mdl[0]);
      xPin = (xOe & xOut) | (~xOe & ~mdl[2] & extLvl) | (~xOe & mdl[2] & xPu);
      chk("padOe", padOe, xOe);
      chk("padOut", padOut, xOut);
      chk("padIe", padIe, ~anaEn);
      chk("padPullup", padPullup, xPu);
      chk("padSlew", padSlew, mdl[3] & xOe);
      chk("padHighDrive", padHighDrive, mdl[4]);
      chk("perDi", perDi, xPin & ~anaEn);
      for (int p = 0; p < 4; p++) begin
         for (int r = 0; r < 8; r++) rd(p, r);
      end
   endtask : check_all

   initial begin
      #80000;
      fail_count++;
      tally_and_finish();
   end

   initial begin
      void'($urandom(13160));
      for (int r = 0; r < 5; r++) mdl[r] = 16'h0000;
      repeat (16) @(posedge mclk);
      sysRst <= 1'b0;
      check_all();
      for (int it = 0; it < 40; it++) begin
         if (it == 20) begin
            // second reset in mid-run, with a live configuration
            @(posedge mclk);
            sysRst <= 1'b1;
            perEn <= 16'h0000;
            perOe <= 16'h0000;
            perDo <= 16'h0000;
            // all pins analog with inputs: every data read must give zero
            anaEn <= 16'hFFFF;
            repeat (2) @(posedge mclk);
            sysRst <= 1'b0;
            for (int r = 0; r < 5; r++) mdl[r] = 16'h0000;
            check_all();
         end
         for (int p = 0; p < 3; p++) begin
            wr(p, 0, 8'($urandom));
            for (int r = 1; r < 5; r++) wr(p, r, 8'($urandom));
         end
         wr(3, $urandom_range(0, 7), 8'($urandom));
         wr($urandom_range(0, 2), $urandom_range(5, 7), 8'($urandom));
         @(posedge mclk);
         perEn <= 16'($urandom);
         perOe <= 16'($urandom);
         perDo <= 16'($urandom);
         anaEn <= 16'($urandom & $urandom);
         extLvl <= 16'($urandom);
         check_all();
      end
      tally_and_finish();
   end
endmodule : testbench
